// ### rtl/scr_config_regs.sv
// Serial channel configuration register bank with APB access
//
// Contract
// RULE_01 - Half-rate bit 1: serial input at 8x reference, byte clock ref/4.
// RULE_02 - Half-rate bit 0: serial input at 16x reference, byte clock ref/2.
// RULE_03 - Half-rate bit clears to 0 on device reset.
// RULE_04 - Receiver power-down bit 1 powers receive parts down; resets to 0.
// RULE_05 - Receive register bits 2 to 7 reserved; bit 2 resets to 1.
// RULE_06 - Channel alarm gate bit 1 blocks all that channel's alarms.
// RULE_07 - Channel alarm gate overrides the per-alarm enable bits.
// RULE_08 - Channel alarm gate resets to 1, alarms start masked.
// RULE_09 - Channel soft reset resets channel logic, keeps configuration.
// RULE_10 - Soft reset never self-clears; software sets and clears it.
// RULE_11 - Channel soft reset bit clears to 0 on device reset.
// RULE_12 - Channel test enable puts transmit and receive into test mode.
// RULE_13 - Software also programs the loopback select for the wanted test.
// RULE_14 - Block test enable overrides each channel test enable.
// RULE_15 - Loopback select 0 gives far-end loopback, transmitter to receiver.
// RULE_16 - Loopback select 1 gives near-end loopback, receiver to transmitter.
// RULE_17 - Software keeps test register bits 1 to 7 zero; they reset zero.
// RULE_18 - Block alarm gate overrides channel gates, masks all; resets to 1.
// RULE_19 - Block soft reset overrides channel resets, resets all four.
// RULE_20 - Bit 0 of every register byte is its most significant bit.
// RULE_21 - Reads return last written or reset value, with no side effect.
`timescale 1ns/1ps
`default_nettype none

module scr_config_regs
  import scr_pkg::*;
#(
  parameter int NUM_CHANNELS       = scr_pkg::NUM_CH,
  parameter int CHANNELS_PER_BLOCK = scr_pkg::CH_PER_BLOCK
)
(
  // Clock and reset
  input  wire logic                            clock_in,
  input  wire logic                            reset_n_in,
  // APB slave
  input  wire logic                            psel_in,
  input  wire logic                            penable_in,
  input  wire logic                            pwrite_in,
  input  wire logic [scr_pkg::APB_ADDR_W-1:0]  paddr_in,
  input  wire logic [scr_pkg::APB_DATA_W-1:0]  pwdata_in,
  input  wire logic [3:0]                      pstrb_in,
  output logic                                 pready_out,
  output logic [scr_pkg::APB_DATA_W-1:0]       prdata_out,
  output logic                                 pslverr_out,
  // Alarm sources and per-alarm enables
  input  wire logic [scr_pkg::NUM_CH-1:0]      tx_alarm_in,
  input  wire logic [scr_pkg::NUM_CH-1:0]      rx_alarm_in,
  input  wire logic [scr_pkg::NUM_CH-1:0]      tx_alarm_enable_in,
  input  wire logic [scr_pkg::NUM_CH-1:0]      rx_alarm_enable_in,
  // Channel controls
  output logic [scr_pkg::NUM_CH-1:0]           rx_half_rate_sel_out,
  output logic [scr_pkg::NUM_CH-1:0][4:0]      serial_rx_input_mult_out,
  output logic [scr_pkg::NUM_CH-1:0]           rx_byte_clock_en_out,
  output logic [scr_pkg::NUM_CH-1:0]           rx_power_down_out,
  output logic [scr_pkg::NUM_CH-1:0]           channel_reset_out,
  output logic [scr_pkg::NUM_CH-1:0]           channel_alarm_out,
  output logic [scr_pkg::NUM_CH-1:0]           test_mode_out,
  output logic [scr_pkg::NUM_CH-1:0]           far_end_loopback_out,
  output logic [scr_pkg::NUM_CH-1:0]           near_end_loopback_out
);
  import scr_pkg::*;

  // Elaboration check: the address map is fixed at eight channels
  if (NUM_CHANNELS != NUM_CH || CHANNELS_PER_BLOCK != CH_PER_BLOCK)
  begin : g_shape_check
    $error("Address map serves eight channels in blocks of four");
  end

  // Register storage
  logic [7:0] rx_cfg  [NUM_CH];
  logic [7:0] com_cfg [NUM_CH];
  logic [7:0] tst_sel [NUM_CH];
  logic [7:0] blk_ctl [NUM_BLOCKS];

  // Address decode
  wire logic [REG_IDX_W-1:0] reg_idx = paddr_in[APB_ADDR_W-1:2];
  wire logic                 word_ok = (paddr_in[1:0] == 2'h0);
  logic [NUM_CH-1:0]     hit_rx;
  logic [NUM_CH-1:0]     hit_com;
  logic [NUM_CH-1:0]     hit_tst;
  logic [NUM_BLOCKS-1:0] hit_blk;

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_dec
    assign hit_rx[i]  = word_ok && (reg_idx == RX_CFG_IDX[i]);
    assign hit_com[i] = word_ok && (reg_idx == COM_CFG_IDX[i]);
    assign hit_tst[i] = word_ok && (reg_idx == TST_SEL_IDX[i]);
  end

  for (genvar b = 0; b < NUM_BLOCKS; b++)
  begin : g_bdec
    assign hit_blk[b] = word_ok && (reg_idx == BLK_CTL_IDX[b]);
  end

  wire logic mapped      = |{hit_rx, hit_com, hit_tst, hit_blk};
  wire logic access      = psel_in && penable_in;
  wire logic next_pready = access && !pready_out;
  wire logic wr_fire     = access && pready_out && pwrite_in &&
                           pstrb_in[0] && mapped;
  wire logic [7:0] wbyte = pwdata_in[7:0];

  // Read selection, no state changes on a read
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (hit_rx[i])
        rd_byte = rd_byte | rx_cfg[i];  // [RULE_21]
      if (hit_com[i])
        rd_byte = rd_byte | com_cfg[i];
      if (hit_tst[i])
        rd_byte = rd_byte | tst_sel[i];
    end
    for (int b = 0; b < NUM_BLOCKS; b++)
    begin
      if (hit_blk[b])
        rd_byte = rd_byte | blk_ctl[b];
    end
  end

  // APB answer, one wait state
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= next_pready;
      pslverr_out <= next_pready && !mapped;
      if (next_pready)
        prdata_out <= {24'h00_0000, rd_byte};
    end
  end

  // Channel registers, written only by software
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_reg
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
      begin
        rx_cfg[i]  <= RX_CFG_RST;   // [RULE_03] [RULE_04] [RULE_05]
        com_cfg[i] <= COM_CFG_RST;  // [RULE_08] [RULE_11]
        tst_sel[i] <= TST_SEL_RST;  // [RULE_17]
      end
      else if (wr_fire)
      begin
        if (hit_rx[i])
          rx_cfg[i] <= wbyte;
        if (hit_com[i])
          com_cfg[i] <= wbyte;  // [RULE_10]
        if (hit_tst[i])
          tst_sel[i] <= wbyte;
      end
    end
  end

  for (genvar b = 0; b < NUM_BLOCKS; b++)
  begin : g_blk
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
        blk_ctl[b] <= BLK_CTL_RST;  // [RULE_18]
      else if (wr_fire && hit_blk[b])
        blk_ctl[b] <= wbyte;
    end
  end

  // Per-channel control decode
  logic [NUM_CH-1:0]      next_half;
  logic [NUM_CH-1:0][4:0] next_mult;
  logic [NUM_CH-1:0]      next_pd;
  logic [NUM_CH-1:0]      next_rst;
  logic [NUM_CH-1:0]      next_alarm;
  logic [NUM_CH-1:0]      next_test;
  logic [NUM_CH-1:0]      next_far;
  logic [NUM_CH-1:0]      next_near;
  logic [NUM_CH-1:0]      next_byte_en;
  logic [NUM_CH-1:0][1:0] byte_cnt;
  logic [NUM_CH-1:0][1:0] next_byte_cnt;

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    localparam int B = i / CH_PER_BLOCK;
    wire logic half = cfg_bit(rx_cfg[i], RX_HALF_RATE_POS);  // [RULE_20]
    wire logic gate = cfg_bit(com_cfg[i], CH_GATE_POS) ||
                      cfg_bit(blk_ctl[B], BLK_GATE_POS);  // [RULE_18]
    wire logic test = cfg_bit(com_cfg[i], CH_TEST_EN_POS) ||
                      cfg_bit(blk_ctl[B], BLK_TEST_EN_POS);  // [RULE_14]
    wire logic loop = cfg_bit(tst_sel[i], LOOP_SEL_POS);
    wire logic [2:0] div = half ? HALF_RATE_DIV : FULL_RATE_DIV;
    wire logic wrap = ({1'b0, byte_cnt[i]} == div - 3'h1);

    assign next_half[i] = half;
    // Serial rate multiple of the reference clock
    assign next_mult[i] = half ? HALF_RATE_MULT  // [RULE_01]
                               : FULL_RATE_MULT;  // [RULE_02]
    assign next_pd[i] = cfg_bit(rx_cfg[i], RX_POWER_DOWN_POS) ||
                        cfg_bit(blk_ctl[B], BLK_RX_PD_POS);  // [RULE_04]
    // Configuration stays untouched while the channel is held in reset
    assign next_rst[i] = cfg_bit(com_cfg[i], CH_SOFT_RST_POS) ||  // [RULE_09]
                         cfg_bit(blk_ctl[B], BLK_SOFT_RST_POS);  // [RULE_19]
    // Channel gate wins over the individual alarm enables
    assign next_alarm[i] = !gate &&  // [RULE_06] [RULE_07]
                           ((tx_alarm_in[i] && tx_alarm_enable_in[i]) ||
                            (rx_alarm_in[i] && rx_alarm_enable_in[i]));
    assign next_test[i] = test;  // [RULE_12]
    assign next_far[i]  = test && !loop;  // [RULE_15]
    assign next_near[i] = test && loop;  // [RULE_16]
    // Byte clock enable at ref/4 or ref/2, held off during channel reset
    assign next_byte_en[i]  = !next_rst[i] && wrap;  // [RULE_01] [RULE_02]
    assign next_byte_cnt[i] = (next_rst[i] || wrap) ? 2'h0
                                                    : byte_cnt[i] + 2'h1;
  end

  // Registered channel outputs
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rx_half_rate_sel_out     <= '0;
      serial_rx_input_mult_out <= {NUM_CH{FULL_RATE_MULT}};
      rx_byte_clock_en_out     <= '0;
      byte_cnt                 <= '0;
      rx_power_down_out        <= '0;
      channel_reset_out        <= '0;
      channel_alarm_out        <= '0;
      test_mode_out            <= '0;
      far_end_loopback_out     <= '0;
      near_end_loopback_out    <= '0;
    end
    else
    begin
      rx_half_rate_sel_out     <= next_half;
      serial_rx_input_mult_out <= next_mult;
      rx_byte_clock_en_out     <= next_byte_en;
      byte_cnt                 <= next_byte_cnt;
      rx_power_down_out        <= next_pd;
      channel_reset_out        <= next_rst;
      channel_alarm_out        <= next_alarm;
      test_mode_out            <= next_test;
      far_end_loopback_out     <= next_far;
      near_end_loopback_out    <= next_near;
    end
  end

endmodule : scr_config_regs

`default_nettype wire

// ### rtl/scr_pkg.sv
// Package of offsets, field positions and reset values for the channel bank
package scr_pkg;

  // Bank shape
  localparam int NUM_CH       = 8;
  localparam int CH_PER_BLOCK = 4;
  localparam int NUM_BLOCKS   = 2;

  // Bus shape
  localparam int APB_ADDR_W = 20;
  localparam int APB_DATA_W = 32;
  localparam int REG_IDX_W  = 18;

  // Register indices; byte address is four times the index
  localparam logic [REG_IDX_W-1:0] RX_CFG_IDX [NUM_CH] = '{
    18'h30003, 18'h30013, 18'h30023, 18'h30033,
    18'h30103, 18'h30113, 18'h30123, 18'h30133};
  localparam logic [REG_IDX_W-1:0] COM_CFG_IDX [NUM_CH] = '{
    18'h30004, 18'h30014, 18'h30024, 18'h30034,
    18'h30104, 18'h30114, 18'h30124, 18'h30134};
  localparam logic [REG_IDX_W-1:0] TST_SEL_IDX [NUM_CH] = '{
    18'h30006, 18'h30016, 18'h30026, 18'h30036,
    18'h30106, 18'h30116, 18'h30126, 18'h30136};
  localparam logic [REG_IDX_W-1:0] BLK_CTL_IDX [NUM_BLOCKS] = '{
    18'h30005, 18'h30105};

  // Reset values
  localparam logic [7:0] RX_CFG_RST  = 8'h20;
  localparam logic [7:0] COM_CFG_RST = 8'h40;
  localparam logic [7:0] TST_SEL_RST = 8'h00;
  localparam logic [7:0] BLK_CTL_RST = 8'h44;

  // Field positions, bit 0 is the most significant bit of the byte
  localparam logic [2:0] RX_HALF_RATE_POS  = 3'h0;
  localparam logic [2:0] RX_POWER_DOWN_POS = 3'h1;
  localparam logic [2:0] CH_GATE_POS       = 3'h1;
  localparam logic [2:0] CH_SOFT_RST_POS   = 3'h2;
  localparam logic [2:0] CH_TEST_EN_POS    = 3'h7;
  localparam logic [2:0] LOOP_SEL_POS      = 3'h0;
  localparam logic [2:0] BLK_GATE_POS      = 3'h1;
  localparam logic [2:0] BLK_SOFT_RST_POS  = 3'h2;
  localparam logic [2:0] BLK_RX_PD_POS     = 3'h4;
  localparam logic [2:0] BLK_TEST_EN_POS   = 3'h7;

  // Rate figures
  localparam logic [4:0] HALF_RATE_MULT = 5'h08;
  localparam logic [4:0] FULL_RATE_MULT = 5'h10;
  localparam logic [2:0] HALF_RATE_DIV  = 3'h4;
  localparam logic [2:0] FULL_RATE_DIV  = 3'h2;

  // Reads a field numbered from the most significant bit
  function automatic logic cfg_bit(input logic [7:0] value,
                                   input logic [2:0] pos);
    cfg_bit = value[3'h7 - pos];
  endfunction : cfg_bit

endpackage : scr_pkg

// ### dv/scr_config_regs_chk.sv
// Port assertions for the channel configuration bank
`timescale 1ns/1ps
`default_nettype none
module scr_config_regs_chk (
  // Clock, reset and bus
  input wire logic             clock_in,
  input wire logic             reset_n_in,
  input wire logic             psel_in,
  input wire logic             penable_in,
  input wire logic             pready_out,
  input wire logic             pslverr_out,
  input wire logic [31:0]      prdata_out,
  // Alarm sources
  input wire logic [7:0]       tx_alarm_in,
  input wire logic [7:0]       rx_alarm_in,
  input wire logic [7:0]       tx_alarm_enable_in,
  input wire logic [7:0]       rx_alarm_enable_in,
  // Channel controls
  input wire logic [7:0]       rx_half_rate_sel_out,
  input wire logic [7:0][4:0]  serial_rx_input_mult_out,
  input wire logic [7:0]       rx_byte_clock_en_out,
  input wire logic [7:0]       channel_reset_out,
  input wire logic [7:0]       channel_alarm_out,
  input wire logic [7:0]       test_mode_out,
  input wire logic [7:0]       far_end_loopback_out,
  input wire logic [7:0]       near_end_loopback_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready held two cycles");
  ready_wait_a: assert property ($rose(penable_in) && psel_in |=> pready_out)
    else $error("no answer one cycle after access");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  rdata_hold_a: assert property (!pready_out |-> $stable(prdata_out))
    else $error("read data moved between answers");
  mult_sel_a: assert property (serial_rx_input_mult_out[0] ==
    (rx_half_rate_sel_out[0] ? 5'h08 : 5'h10)) else $error("rate multiple wrong");
  full_clk_a: assert property (rx_byte_clock_en_out[0] && !psel_in &&
    !$past(psel_in) && !rx_half_rate_sel_out[0] && !channel_reset_out[0]
    |=> !rx_byte_clock_en_out[0] ##1 rx_byte_clock_en_out[0])
    else $error("full rate byte clock not every 2");
  half_clk_a: assert property (rx_byte_clock_en_out[0] && !psel_in &&
    !$past(psel_in) && rx_half_rate_sel_out[0] && !channel_reset_out[0]
    |=> !rx_byte_clock_en_out[0] [*3]) else $error("half rate pulse early");
  alarm_cause_a: assert property ((channel_alarm_out & ~$past(
    tx_alarm_in & tx_alarm_enable_in | rx_alarm_in & rx_alarm_enable_in))
    == 8'h00) else $error("alarm without enabled source");
  loop_excl_a: assert property ((far_end_loopback_out & near_end_loopback_out)
    == 8'h00) else $error("both loopbacks on");
  loop_test_a: assert property ((far_end_loopback_out | near_end_loopback_out)
    == test_mode_out) else $error("loopback without test mode");
endmodule : scr_config_regs_chk

bind scr_config_regs scr_config_regs_chk chk (.clock_in, .reset_n_in,
  .psel_in, .penable_in, .pready_out, .pslverr_out, .prdata_out,
  .tx_alarm_in, .rx_alarm_in, .tx_alarm_enable_in, .rx_alarm_enable_in,
  .rx_half_rate_sel_out, .serial_rx_input_mult_out, .rx_byte_clock_en_out,
  .channel_reset_out, .channel_alarm_out, .test_mode_out,
  .far_end_loopback_out, .near_end_loopback_out);
`default_nettype wire

// ### dv/serdes_channel_config_regs_tb.sv
// Self-checking bench for the channel configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH at %0t: got %0h want %0h", $time, (a), (b)); end end
module serdes_channel_config_regs_tb;
  import scr_pkg::*;
  logic clock_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, pready_out, pslverr_out;
  logic [19:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out;
  logic [3:0] pstrb_in = 4'hf;
  logic [7:0] tx_alarm_in = 0, rx_alarm_in = 0, tx_alarm_enable_in = 0;
  logic [7:0] rx_alarm_enable_in = 0, rx_half_rate_sel_out, rx_power_down_out;
  logic [7:0] rx_byte_clock_en_out, channel_reset_out, channel_alarm_out;
  logic [7:0] test_mode_out, far_end_loopback_out, near_end_loopback_out;
  logic [7:0][4:0] serial_rx_input_mult_out;
  logic [7:0] rx[8], cm[8], ts[8], bk[2];
  logic [33:0] exq[$];
  logic [33:0] e;
  int miscompares = 0, check_count = 0, seed = 32'h23cc;

  scr_config_regs uut (.clock_in, .reset_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .pready_out, .prdata_out,
    .pslverr_out, .tx_alarm_in, .rx_alarm_in, .tx_alarm_enable_in,
    .rx_alarm_enable_in, .rx_half_rate_sel_out, .serial_rx_input_mult_out,
    .rx_byte_clock_en_out, .rx_power_down_out, .channel_reset_out,
    .channel_alarm_out, .test_mode_out, .far_end_loopback_out,
    .near_end_loopback_out);

  initial
  begin
    forever #50 clock_in = ~clock_in;
  end

  // Answer monitor: oldest expectation against each answer
  always @(posedge clock_in)
    if (pready_out === 1'b1 && exq.size() == 0)
    begin
      miscompares++;
      $display("MISMATCH at %0t: answer without request", $time);
    end
    else if (pready_out === 1'b1)
    begin
      e = exq.pop_front();
      `CHK(pslverr_out, e[33])
      if (e[32])
        `CHK(prdata_out, {24'h0, e[7:0]})
    end

  task automatic apb(input logic w, input logic [19:0] a,
                     input logic [7:0] d, input logic [7:0] x,
                     input logic err = 1'b0);
    int n;
    n = 0;
    exq.push_back({err, !w, 24'h0, x});
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= ($random(seed) << 8) | {24'h0, d};
    @(posedge clock_in);
    penable_in <= 1'b1;
    do @(posedge clock_in); while (pready_out !== 1'b1 && ++n < 50);
    if (n >= 50)
    begin
      miscompares++;
      $display("MISMATCH at %0t: no answer on the bus", $time);
      end_sim();
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic outs();
    logic t;
    logic al;
    tx_alarm_in <= 8'($random(seed));
    rx_alarm_in <= 8'($random(seed));
    tx_alarm_enable_in <= 8'($random(seed));
    rx_alarm_enable_in <= 8'($random(seed));
    repeat (4) @(posedge clock_in);
    for (int c = 0; c < 8; c++)
    begin
      t = cm[c][0] | bk[c/4][0];
      al = tx_alarm_in[c] & tx_alarm_enable_in[c] |
           rx_alarm_in[c] & rx_alarm_enable_in[c];
      `CHK(rx_half_rate_sel_out[c], rx[c][7])
      `CHK(serial_rx_input_mult_out[c], rx[c][7] ? 5'h08 : 5'h10)
      `CHK(rx_power_down_out[c], rx[c][6] | bk[c/4][3])
      `CHK(channel_reset_out[c], cm[c][5] | bk[c/4][5])
      `CHK(test_mode_out[c], t)
      `CHK(far_end_loopback_out[c], t & !ts[c][7])
      `CHK(near_end_loopback_out[c], t & ts[c][7])
      `CHK(channel_alarm_out[c], al & !cm[c][6] & !bk[c/4][6])
    end
  endtask : outs

  task end_sim;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #2000000;
    miscompares++;
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge clock_in);
    reset_n_in <= 1'b1;
    bk = '{8'h44, 8'h44};
    for (int c = 0; c < 8; c++)
    begin
      {rx[c], cm[c], ts[c]} = {8'h20, 8'h40, 8'h00};
      apb(0, {RX_CFG_IDX[c], 2'b00}, 0, 8'h20);
      apb(0, {COM_CFG_IDX[c], 2'b00}, 0, 8'h40);
      apb(0, {TST_SEL_IDX[c], 2'b00}, 0, 8'h00);
    end
    outs();
    for (int c = 0; c < 8; c++)
    begin
      rx[c] = 8'($random(seed));
      cm[c] = 8'($random(seed));
      ts[c] = 8'($random(seed)) & 8'h80;
      apb(1, {RX_CFG_IDX[c], 2'b00}, rx[c], 0);
      apb(1, {COM_CFG_IDX[c], 2'b00}, cm[c], 0);
      apb(1, {TST_SEL_IDX[c], 2'b00}, ts[c], 0);
      apb(0, {RX_CFG_IDX[c], 2'b00}, 0, rx[c]);
      apb(0, {COM_CFG_IDX[c], 2'b00}, 0, cm[c]);
      apb(0, {TST_SEL_IDX[c], 2'b00}, 0, ts[c]);
    end
    outs();
    bk = '{8'h21, 8'h08};
    apb(1, {BLK_CTL_IDX[0], 2'b00}, bk[0], 0);
    apb(1, {BLK_CTL_IDX[1], 2'b00}, bk[1], 0);
    outs();
    apb(0, {COM_CFG_IDX[1], 2'b00}, 0, cm[1]);
    pstrb_in <= 4'he;
    apb(1, {RX_CFG_IDX[0], 2'b00}, ~rx[0], 0);
    pstrb_in <= 4'hf;
    apb(0, {RX_CFG_IDX[0], 2'b00}, 0, rx[0]);
    apb(1, 20'hc001c, 8'h5a, 0, 1'b1);
    apb(0, 20'hc001c, 0, 0, 1'b1);
    bk = '{8'h00, 8'h00};
    {cm[0], rx[0]} = {8'h20, 8'h80};
    apb(1, {BLK_CTL_IDX[0], 2'b00}, 8'h00, 0);
    apb(1, {BLK_CTL_IDX[1], 2'b00}, 8'h00, 0);
    apb(1, {COM_CFG_IDX[0], 2'b00}, cm[0], 0);
    apb(1, {RX_CFG_IDX[0], 2'b00}, rx[0], 0);
    repeat (30) @(posedge clock_in);
    outs();
    cm[0] = 8'h00;
    apb(1, {COM_CFG_IDX[0], 2'b00}, cm[0], 0);
    repeat (20) @(posedge clock_in);
    rx[0] = 8'h00;
    apb(1, {RX_CFG_IDX[0], 2'b00}, rx[0], 0);
    repeat (20) @(posedge clock_in);
    outs();
    end_sim();
  end
endmodule : serdes_channel_config_regs_tb
`default_nettype wire
